//--- hdl/dual_timer_counter.sv
// dual timer/counter with apb register access
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter
  import timer_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external pins
  input wire logic timer0_count_pin,
  input wire logic timer1_count_pin,
  input wire logic ext_interrupt_pin_a,
  input wire logic ext_interrupt_pin_b,
  // toggle outputs
  output logic timer0_toggle_out,
  output logic timer0_toggle_out_oe,
  output logic timer1_toggle_out,
  output logic timer1_toggle_out_oe,
  // serial port baud source
  output logic baud_tick,
  // processor interrupt side
  output logic timer0_irq,
  output logic timer1_irq,
  input wire logic timer0_isr_ack,
  input wire logic timer1_isr_ack
);

  // register state
  logic timer0_run;
  logic timer1_run;
  logic timer0_overflow_flag;
  logic timer1_overflow_flag;
  logic [3:0] ctl_low_bits;
  logic [7:0] timer_mode_config;
  logic [7:0] timer0_low_byte;
  logic [7:0] timer0_high_byte;
  logic [7:0] timer1_low_byte;
  logic [7:0] timer1_high_byte;
  logic [7:0] port3_mode;
  logic [AUX_USED_BITS-1:0] aux_control;

  // bus decode
  logic [IDX_W-1:0] idx;
  logic addr_ok;
  logic mapped;
  logic wr;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  // pins
  logic pin0_fall;
  logic pin1_fall;
  logic int_a_level;
  logic int_b_level;

  // prescaler
  logic [3:0] prescale_cnt;
  logic prescale_tick;

  // counting
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic t0_tick;
  logic t1_tick;
  logic t0_enable;
  logic t1_enable;
  logic th0_split_enable;
  logic [16:0] t0_step;
  logic [16:0] t1_step;
  logic [8:0] th0_split_step;
  logic t0_ovf;
  logic t1_ovf;
  logic th0_ovf;
  logic next_flag0_set;
  logic next_flag1_set;

  // one step of a counter in a given mode: {overflow, high, low}
  function automatic logic [16:0] count_step(
    input logic [1:0] mode,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [16:0] res;
    logic [15:0] word;
    res = {1'b0, hi, lo};
    word = {hi, lo} + WORD_ONE;
    case (mode)
      MODE_13BIT: begin
        // upper low-byte bits untouched; low five bits prescale
        res[MODE0_LOW_BITS-1:0] = lo[MODE0_LOW_BITS-1:0] + 5'h01;
        if (lo[MODE0_LOW_BITS-1:0] == MODE0_LOW_FULL) begin
          res[15:8] = hi + BYTE_ONE;
          res[16] = (hi == BYTE_FULL);
        end
      end
      MODE_16BIT: begin
        res[15:0] = word;
        res[16] = ({hi, lo} == 16'hffff);
      end
      MODE_8BIT_RELOAD: begin
        if (lo == BYTE_FULL) begin
          res[7:0] = hi;
          res[16] = 1'b1;
        end else begin
          res[7:0] = lo + BYTE_ONE;
        end
      end
      default: begin
        // split mode: low byte alone as an 8-bit counter
        res[7:0] = lo + BYTE_ONE;
        res[16] = (lo == BYTE_FULL);
      end
    endcase
    return res;
  endfunction

  // pin synchronisers
  pin_edge_sync u_sync_count0 (
    .pclk(pclk),
    .presetn(presetn),
    .pin(timer0_count_pin),
    .level(),
    .fall(pin0_fall)
  );

  pin_edge_sync u_sync_count1 (
    .pclk(pclk),
    .presetn(presetn),
    .pin(timer1_count_pin),
    .level(),
    .fall(pin1_fall)
  );

  pin_edge_sync u_sync_int_a (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ext_interrupt_pin_a),
    .level(int_a_level),
    .fall()
  );

  pin_edge_sync u_sync_int_b (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ext_interrupt_pin_b),
    .level(int_b_level),
    .fall()
  );

  // apb decode: zero wait states
  assign idx = paddr[IDX_MSB:IDX_LSB];
  assign addr_ok = (paddr[ADDR_W-1:IDX_MSB+1] == ADDR_TOP_ZERO);
  always_comb begin
    case (idx)
      IDX_TIMER_CONTROL_FLAGS,
      IDX_TIMER_MODE_CONFIG,
      IDX_TIMER0_COUNT_LOW,
      IDX_TIMER1_COUNT_LOW,
      IDX_TIMER0_COUNT_HIGH,
      IDX_TIMER1_COUNT_HIGH,
      IDX_PORT3_MODE_AND_TIMER_OUTPUT,
      IDX_TIMER_AUX_CONTROL: mapped = addr_ok;
      default: mapped = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr = psel & penable & pwrite & mapped & pstrb[0];
  assign wbyte = pwdata[7:0];

  always_comb begin
    case (idx)
      IDX_TIMER_CONTROL_FLAGS: rbyte = {timer1_overflow_flag, timer1_run,
                                        timer0_overflow_flag, timer0_run, ctl_low_bits};
      IDX_TIMER_MODE_CONFIG: rbyte = timer_mode_config;
      IDX_TIMER0_COUNT_LOW: rbyte = timer0_low_byte;
      IDX_TIMER1_COUNT_LOW: rbyte = timer1_low_byte;
      IDX_TIMER0_COUNT_HIGH: rbyte = timer0_high_byte;
      IDX_TIMER1_COUNT_HIGH: rbyte = timer1_high_byte;
      IDX_PORT3_MODE_AND_TIMER_OUTPUT: rbyte = port3_mode;
      IDX_TIMER_AUX_CONTROL: rbyte = {5'h00, aux_control};
      default: rbyte = RESET_BYTE;
    endcase
  end

  // read data captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= mapped ? {24'h00_0000, rbyte} : 32'h0000_0000;
    end
  end

  // plain control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer0_run <= 1'b0;
      timer1_run <= 1'b0;
      ctl_low_bits <= 4'h0;
      timer_mode_config <= RESET_BYTE;
      port3_mode <= RESET_BYTE;
      aux_control <= 3'h0;
    end else if (wr) begin
      if (idx == IDX_TIMER_CONTROL_FLAGS) begin
        timer0_run <= wbyte[CTL_TIMER0_RUN];
        timer1_run <= wbyte[CTL_TIMER1_RUN];
        ctl_low_bits <= wbyte[3:0];
      end
      if (idx == IDX_TIMER_MODE_CONFIG) begin
        timer_mode_config <= wbyte;
      end
      if (idx == IDX_PORT3_MODE_AND_TIMER_OUTPUT) begin
        port3_mode <= wbyte;
      end
      if (idx == IDX_TIMER_AUX_CONTROL) begin
        aux_control <= wbyte[AUX_USED_BITS-1:0];
      end
    end
  end

  // internal clock prescaler: clock/12 or clock/4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_cnt <= PRESCALE_ONE;
    end else if (prescale_tick) begin
      prescale_cnt <= PRESCALE_ONE;
    end else begin
      prescale_cnt <= prescale_cnt + PRESCALE_ONE;
    end
  end
  assign prescale_tick = aux_control[AUX_CLOCK_DIV4] ? (prescale_cnt >= PRESCALE_DIV4)
                                                     : (prescale_cnt >= PRESCALE_DIV12);

  // mode fields
  assign mode0 = {timer_mode_config[CFG_MODE0_HI], timer_mode_config[CFG_MODE0_LO]};
  assign mode1 = {timer_mode_config[CFG_MODE1_HI], timer_mode_config[CFG_MODE1_LO]};

  // count sources
  assign t0_tick = timer_mode_config[CFG_CT0] ? pin0_fall : prescale_tick;
  assign t1_tick = timer_mode_config[CFG_CT1] ? pin1_fall : prescale_tick;

  // gating: run bit and optional interrupt-pin gate
  assign t0_enable = t0_tick & timer0_run
                     & (~timer_mode_config[CFG_GATE0] | int_a_level);
  // with timer 0 split, timer 1 loses its run bit and stops only in mode 3 or when gated off by pin b
  assign t1_enable = t1_tick & (mode1 != MODE_SPLIT)
                     & ((mode0 == MODE_SPLIT) | timer1_run)
                     & (~timer_mode_config[CFG_GATE1] | int_b_level);
  // split high byte: internal clock only, run by timer 1 run bit
  assign th0_split_enable = (mode0 == MODE_SPLIT) & prescale_tick & timer1_run;

  assign t0_step = count_step(mode0, timer0_low_byte, timer0_high_byte);
  assign t1_step = count_step(mode1, timer1_low_byte, timer1_high_byte);
  assign th0_split_step = {1'b0, timer0_high_byte} + {1'b0, BYTE_ONE};

  assign t0_ovf = t0_enable & t0_step[16];
  assign t1_ovf = t1_enable & t1_step[16];
  assign th0_ovf = th0_split_enable & th0_split_step[8];

  // timer 0 count bytes; a software write wins over a count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer0_low_byte <= RESET_BYTE;
    end else if (wr && idx == IDX_TIMER0_COUNT_LOW) begin
      timer0_low_byte <= wbyte;
    end else if (t0_enable) begin
      timer0_low_byte <= t0_step[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer0_high_byte <= RESET_BYTE;
    end else if (wr && idx == IDX_TIMER0_COUNT_HIGH) begin
      timer0_high_byte <= wbyte;
    end else if (mode0 == MODE_SPLIT) begin
      if (th0_split_enable) begin
        timer0_high_byte <= th0_split_step[7:0];
      end
    end else if (t0_enable) begin
      timer0_high_byte <= t0_step[15:8];
    end
  end

  // timer 1 count bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer1_low_byte <= RESET_BYTE;
    end else if (wr && idx == IDX_TIMER1_COUNT_LOW) begin
      timer1_low_byte <= wbyte;
    end else if (t1_enable) begin
      timer1_low_byte <= t1_step[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer1_high_byte <= RESET_BYTE;
    end else if (wr && idx == IDX_TIMER1_COUNT_HIGH) begin
      timer1_high_byte <= wbyte;
    end else if (t1_enable) begin
      timer1_high_byte <= t1_step[15:8];
    end
  end

  // overflow flags: hardware set beats software clear and service clear
  assign next_flag0_set = t0_ovf;
  assign next_flag1_set = (mode0 == MODE_SPLIT) ? th0_ovf : t1_ovf;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer0_overflow_flag <= 1'b0;
    end else if (next_flag0_set) begin
      timer0_overflow_flag <= 1'b1;
    end else if (wr && idx == IDX_TIMER_CONTROL_FLAGS) begin
      timer0_overflow_flag <= wbyte[CTL_TIMER0_OVERFLOW_FLAG];
    end else if (timer0_isr_ack) begin
      timer0_overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer1_overflow_flag <= 1'b0;
    end else if (next_flag1_set) begin
      timer1_overflow_flag <= 1'b1;
    end else if (wr && idx == IDX_TIMER_CONTROL_FLAGS) begin
      timer1_overflow_flag <= wbyte[CTL_TIMER1_OVERFLOW_FLAG];
    end else if (timer1_isr_ack) begin
      timer1_overflow_flag <= 1'b0;
    end
  end

  // interrupt requests to the processor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer0_irq <= 1'b0;
      timer1_irq <= 1'b0;
    end else begin
      timer0_irq <= (next_flag0_set | (timer0_overflow_flag & ~timer0_isr_ack))
                    & aux_control[AUX_TIMER0_IRQ_ENABLE];
      timer1_irq <= (next_flag1_set | (timer1_overflow_flag & ~timer1_isr_ack))
                    & aux_control[AUX_TIMER1_IRQ_ENABLE];
    end
  end

  // overflow-driven toggle outputs and baud tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer0_toggle_out <= 1'b0;
      timer1_toggle_out <= 1'b0;
      baud_tick <= 1'b0;
    end else begin
      if (t0_ovf && port3_mode[P3_TIMER0_TOGGLE_OUT_ENABLE]) begin
        timer0_toggle_out <= ~timer0_toggle_out;
      end
      if (t1_ovf && port3_mode[P3_TIMER1_TOGGLE_OUT_ENABLE]) begin
        timer1_toggle_out <= ~timer1_toggle_out;
      end
      baud_tick <= t1_ovf;
    end
  end

  assign timer0_toggle_out_oe = port3_mode[P3_TIMER0_TOGGLE_OUT_ENABLE];
  assign timer1_toggle_out_oe = port3_mode[P3_TIMER1_TOGGLE_OUT_ENABLE];

endmodule // dual_timer_counter
`default_nettype wire

//--- hdl/timer_pkg.sv
// constants and register map for the dual timer/counter
package timer_pkg;

  // apb geometry: register index sits in paddr[9:2]
  localparam int ADDR_W = 12;
  localparam int IDX_W = 8;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam logic [1:0] ADDR_TOP_ZERO = 2'h0;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TIMER_CONTROL_FLAGS = 8'h88;
  localparam logic [IDX_W-1:0] IDX_TIMER_MODE_CONFIG = 8'h89;
  localparam logic [IDX_W-1:0] IDX_TIMER0_COUNT_LOW = 8'h8a;
  localparam logic [IDX_W-1:0] IDX_TIMER1_COUNT_LOW = 8'h8b;
  localparam logic [IDX_W-1:0] IDX_TIMER0_COUNT_HIGH = 8'h8c;
  localparam logic [IDX_W-1:0] IDX_TIMER1_COUNT_HIGH = 8'h8d;
  localparam logic [IDX_W-1:0] IDX_PORT3_MODE_AND_TIMER_OUTPUT = 8'h96;
  localparam logic [IDX_W-1:0] IDX_TIMER_AUX_CONTROL = 8'h97;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // control/flags bit positions
  localparam int CTL_TIMER1_OVERFLOW_FLAG = 7;
  localparam int CTL_TIMER1_RUN = 6;
  localparam int CTL_TIMER0_OVERFLOW_FLAG = 5;
  localparam int CTL_TIMER0_RUN = 4;

  // mode config bit positions
  localparam int CFG_GATE1 = 7;
  localparam int CFG_CT1 = 6;
  localparam int CFG_MODE1_HI = 5;
  localparam int CFG_MODE1_LO = 4;
  localparam int CFG_GATE0 = 3;
  localparam int CFG_CT0 = 2;
  localparam int CFG_MODE0_HI = 1;
  localparam int CFG_MODE0_LO = 0;

  // port3 mode bits that steer the toggle outputs
  localparam int P3_TIMER1_TOGGLE_OUT_ENABLE = 3;
  localparam int P3_TIMER0_TOGGLE_OUT_ENABLE = 2;

  // aux control bit positions
  localparam int AUX_TIMER0_IRQ_ENABLE = 0;
  localparam int AUX_TIMER1_IRQ_ENABLE = 1;
  localparam int AUX_CLOCK_DIV4 = 2;
  localparam int AUX_USED_BITS = 3;

  // mode field encodings
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_8BIT_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  // mode 0 prescale geometry
  localparam int MODE0_LOW_BITS = 5;
  localparam logic [4:0] MODE0_LOW_FULL = 5'h1f;
  localparam logic [7:0] BYTE_FULL = 8'hff;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  localparam logic [7:0] BYTE_ONE = 8'h01;

  // internal clock prescale
  localparam logic [3:0] PRESCALE_DIV12 = 4'hc;
  localparam logic [3:0] PRESCALE_DIV4 = 4'h4;
  localparam logic [3:0] PRESCALE_ONE = 4'h1;

endpackage : timer_pkg

//--- hdl/pin_edge_sync.sv
// two-flop pin synchroniser with falling-edge detector
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin side
  input wire logic pin,
  // synchronised side
  output logic level,
  output logic fall
);
  logic meta;
  logic sync;
  logic prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level = sync;
  // compare successive synchronised samples
  assign fall = prev & ~sync;

endmodule // pin_edge_sync
`default_nettype wire

//--- verification/timer_chk.sv
// port checker for the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
module timer_chk
  import timer_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // outputs under watch
  input wire logic timer0_toggle_out,
  input wire logic timer0_toggle_out_oe,
  input wire logic timer1_toggle_out,
  input wire logic timer1_toggle_out_oe,
  input wire logic baud_tick,
  input wire logic timer0_irq,
  input wire logic timer0_isr_ack
);
  logic [31:0] pwdata_q;
  logic p3_write;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk) begin
    pwdata_q <= pwdata;
  end
  assign p3_write = psel && penable && pwrite && pstrb[0] && (paddr[11:10] == 2'h0)
    && (paddr[9:2] == IDX_PORT3_MODE_AND_TIMER_OUTPUT);
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_slverr_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  a_slverr_top_bits: assert property (psel && penable && paddr[11:10] != 2'h0 |-> pslverr)
    else $error("no error on out-of-range address");
  a_prdata_upper: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_unmapped_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_baud_single: assert property (baud_tick |=> !baud_tick)
    else $error("baud tick longer than one cycle");
  a_tog0_needs_oe: assert property ($changed(timer0_toggle_out) |->
    timer0_toggle_out_oe || $past(timer0_toggle_out_oe))
    else $error("timer0 toggle without enable");
  a_tog1_needs_oe: assert property ($changed(timer1_toggle_out) |->
    timer1_toggle_out_oe || $past(timer1_toggle_out_oe))
    else $error("timer1 toggle without enable");
  a_oe_from_write: assert property (p3_write |=>
    {timer1_toggle_out_oe, timer0_toggle_out_oe} == pwdata_q[3:2])
    else $error("toggle enables not taken from write");
  a_irq_ack_clear: assert property ($rose(timer0_isr_ack) |-> ##2 !timer0_irq)
    else $error("interrupt not cleared by service");
endmodule // timer_chk
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin mismatches++; $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module testbench;
  import timer_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic t0_pin, t1_pin, pin_a, pin_b, ack0, ack1;
  logic tog0, oe0, tog1, oe1, baud_tick, irq0, irq1;
  logic [7:0] rd, keep;
  logic err;
  logic [7:0] regs [5] = '{8'h88, 8'h8a, 8'h8b, 8'h8c, 8'h96};
  int mismatches, check_count, baud_count;
  dual_timer_counter dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer0_count_pin(t0_pin), .timer1_count_pin(t1_pin),
    .ext_interrupt_pin_a(pin_a), .ext_interrupt_pin_b(pin_b),
    .timer0_toggle_out(tog0), .timer0_toggle_out_oe(oe0),
    .timer1_toggle_out(tog1), .timer1_toggle_out_oe(oe1), .baud_tick(baud_tick),
    .timer0_irq(irq0), .timer1_irq(irq1), .timer0_isr_ack(ack0), .timer1_isr_ack(ack1)
  );
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (baud_tick === 1'b1) baud_count++;
  end
  task automatic close_out();
    if (mismatches == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= wr_en ? 4'h1 : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {2'h0, idx, 2'h0}, d);
  endtask
  task automatic rdr(input logic [7:0] idx);
    apb(1'b0, {2'h0, idx, 2'h0}, 8'h00);
  endtask
  task automatic load(input logic [7:0] cfg, hi_i, hv, lo_i, lv, ctl);
    wr(8'h89, cfg);
    wr(hi_i, hv);
    wr(lo_i, lv);
    wr(8'h88, ctl);
  endtask
  task automatic wait_flag(input int b);
    for (int i = 0; i < 300; i++) begin
      rdr(8'h88);
      if (rd[b] === 1'b1) break;
    end
    `CHK("overflow flag", 1'b1, rd[b])
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    mismatches++;
    close_out();
  end
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    t0_pin = 1'b1;
    t1_pin = 1'b1;
    pin_a = 1'b1;
    pin_b = 1'b1;
    ack0 = 1'b0;
    ack1 = 1'b0;
    mismatches = 0;
    check_count = 0;
    baud_count = 0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and refused addresses
    foreach (regs[i]) begin
      rdr(regs[i]);
      `CHK("reset value", 8'h00, rd)
    end
    rdr(8'h80);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 8'h00, rd)
    apb(1'b0, 12'h620, 8'h00);
    `CHK("top bits error", 1'b1, err)
    // toggle enables, then div4 prescale
    wr(8'h96, 8'ha5);
    rdr(8'h96);
    `CHK("port3 readback", 8'ha5, rd)
    `CHK("timer0 oe", 1'b1, oe0)
    `CHK("timer1 oe", 1'b0, oe1)
    wr(8'h96, 8'h0c);
    // div4 prescale, timer 0 interrupt enabled, timer 1 interrupt masked
    wr(8'h97, 8'h05);
    // mode 0 wrap from 1fff
    load(8'h00, 8'h8c, 8'hff, 8'h8a, 8'hfe, 8'h10);
    wait_flag(5);
    wr(8'h88, 8'h20);
    `CHK("irq0 raised", 1'b1, irq0)
    `CHK("toggle0 first", 1'b1, tog0)
    rdr(8'h8c);
    `CHK("mode0 high", 8'h00, rd)
    rdr(8'h8a);
    `CHK("mode0 low top", 3'h7, rd[7:5])
    keep = rd;
    repeat (40) @(posedge pclk);
    rdr(8'h8a);
    `CHK("halted count", keep, rd)
    @(posedge pclk);
    ack0 <= 1'b1;
    @(posedge pclk);
    ack0 <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("irq0 after ack", 1'b0, irq0)
    rdr(8'h88);
    `CHK("flag after ack", 8'h00, rd)
    // mode 1 wrap from ffff
    load(8'h01, 8'h8c, 8'hff, 8'h8a, 8'hfe, 8'h10);
    wait_flag(5);
    wr(8'h88, 8'h00);
    rdr(8'h8c);
    `CHK("mode1 high", 8'h00, rd)
    rdr(8'h8a);
    `CHK("mode1 low top", 4'h0, rd[7:4])
    `CHK("toggle0 second", 1'b0, tog0)
    // mode 2 reload
    load(8'h02, 8'h8c, 8'hf0, 8'h8a, 8'hfe, 8'h10);
    wait_flag(5);
    wr(8'h88, 8'h00);
    rdr(8'h8c);
    `CHK("reload kept", 8'hf0, rd)
    rdr(8'h8a);
    `CHK("reloaded low", 4'hf, rd[7:4])
    `CHK("no baud from t0", 1'b1, baud_count == 0)
    // timer 1 mode 2 drives the baud tick
    load(8'h20, 8'h8d, 8'hff, 8'h8b, 8'hfe, 8'h40);
    wait_flag(7);
    `CHK("irq1 masked", 1'b0, irq1)
    wr(8'h88, 8'h00);
    repeat (2) @(posedge pclk);
    `CHK("baud from t1", 1'b1, baud_count != 0)
    `CHK("toggle1 parity", baud_count[0], tog1)
    // timer 1 mode 3 freezes
    load(8'h30, 8'h8d, 8'h00, 8'h8b, 8'h55, 8'h40);
    repeat (60) @(posedge pclk);
    rdr(8'h8b);
    `CHK("t1 frozen", 8'h55, rd)
    wr(8'h88, 8'h00);
    // gate on pin a
    pin_a <= 1'b0;
    load(8'h09, 8'h8c, 8'h00, 8'h8a, 8'h00, 8'h10);
    repeat (60) @(posedge pclk);
    rdr(8'h8a);
    `CHK("gated off", 8'h00, rd)
    pin_a <= 1'b1;
    repeat (60) @(posedge pclk);
    rdr(8'h8a);
    `CHK("gated on", 1'b1, rd != 8'h00)
    wr(8'h88, 8'h00);
    // count pin falls
    load(8'h05, 8'h8c, 8'h00, 8'h8a, 8'h00, 8'h10);
    repeat (3) begin
      @(posedge pclk);
      t0_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      t0_pin <= 1'b1;
      repeat (6) @(posedge pclk);
    end
    rdr(8'h8a);
    `CHK("pin falls", 8'h03, rd)
    wr(8'h88, 8'h00);
    // timer 0 split, high byte on timer 1 run
    load(8'h03, 8'h8c, 8'hfe, 8'h8a, 8'h00, 8'h40);
    wait_flag(7);
    wr(8'h88, 8'h00);
    rdr(8'h8a);
    `CHK("split low idle", 8'h00, rd)
    rdr(8'h8c);
    `CHK("split high wrap", 4'h0, rd[7:4])
    // timer 1 keeps counting without its run bit while timer 0 is split
    rdr(8'h8b);
    keep = rd;
    repeat (20) @(posedge pclk);
    rdr(8'h8b);
    `CHK("t1 runs unowned", 1'b1, rd != keep)
    close_out();
  end
endmodule // testbench
bind dual_timer_counter timer_chk chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer0_toggle_out(timer0_toggle_out),
  .timer0_toggle_out_oe(timer0_toggle_out_oe), .timer1_toggle_out(timer1_toggle_out),
  .timer1_toggle_out_oe(timer1_toggle_out_oe), .baud_tick(baud_tick),
  .timer0_irq(timer0_irq), .timer0_isr_ack(timer0_isr_ack)
);
`default_nettype wire
